// File: rtl/fdb_pkg.sv
package fdb_pkg;

    // ------------------------------------------------------------
    // block lengths and fixed offsets
    // ------------------------------------------------------------
    localparam logic [6:0] FDB_DEF_LEN      = 7'h06;
    localparam logic [6:0] FDB_ID_LEN       = 7'h1F;
    localparam logic [6:0] FDB_MOD_LEN      = 7'h3F;
    localparam logic [6:0] FDB_MSG_LEN      = 7'h3C;
    localparam logic [6:0] FDB_H_LEN        = 7'h08;
    localparam logic [6:0] FDB_IRQ_HDR_LEN  = 7'h04;
    localparam logic [6:0] FDB_IRQ_INFO_MAX = 7'h3B;
    localparam logic [6:0] FDB_IRQ_FIX_LEN  = 7'h14;
    localparam logic [6:0] FDB_IRQ_MAX      = 7'h3F;
    localparam logic [7:0] FDB_OFS_MOD_FIX  = 8'h25;
    localparam logic [7:0] FDB_OFS_MSG_FIX  = 8'h64;
    localparam logic [7:0] FDB_OFS_IRQ_STD  = 8'hA0;
    localparam logic [7:0] FDB_OFS_IRQ_RED  = 8'hA8;
    localparam int         FDB_ID_SLOTS     = 248;
    localparam int         FDB_SLOTS        = 252;
    localparam int         FDB_FIFO_DEPTH   = 16;

    // ------------------------------------------------------------
    // byte indices and field positions
    // ------------------------------------------------------------
    localparam logic [6:0] FDB_IX_ST1       = 7'h00;
    localparam logic [6:0] FDB_IX_ST2       = 7'h01;
    localparam logic [6:0] FDB_IX_ST3       = 7'h02;
    localparam logic [6:0] FDB_IX_MADDR     = 7'h03;
    localparam logic [6:0] FDB_IX_IDHI      = 7'h04;
    localparam logic [6:0] FDB_IX_MSTATE    = 7'h24;
    localparam logic [6:0] FDB_IX_ITYPE     = 7'h01;
    localparam int         FDB_ST2_PRM      = 0;
    localparam int         FDB_ST2_PRESENT  = 2;
    localparam int         FDB_ST2_WD       = 3;
    localparam int         FDB_ST2_DIS      = 7;
    localparam logic [7:0] FDB_ST2_ZMASK    = 8'h72;

    // ------------------------------------------------------------
    // codes
    // ------------------------------------------------------------
    localparam logic [1:0] FDB_MS_OK        = 2'h0;
    localparam logic [1:0] FDB_MS_FAULT     = 2'h1;
    localparam logic [1:0] FDB_MS_WRONG     = 2'h2;
    localparam logic [1:0] FDB_MS_NONE      = 2'h3;
    localparam logic [7:0] FDB_BMB_OFF      = 8'h00;
    localparam logic [7:0] FDB_BMB_STOP     = 8'h40;
    localparam logic [7:0] FDB_BMB_CLEAR    = 8'h80;
    localparam logic [7:0] FDB_BMB_RUN      = 8'hC0;
    localparam logic [7:0] FDB_IT_DIAG      = 8'h01;
    localparam logic [7:0] FDB_IT_UPDATE    = 8'h06;
    localparam logic [7:0] FDB_IT_MAKER_LO  = 8'h20;
    localparam logic [7:0] FDB_IT_MAKER_HI  = 8'h7E;

    typedef enum logic [1:0] {FDB_BM_OFF, FDB_BM_STOP, FDB_BM_CLEAR, FDB_BM_RUN} fdb_bm_t;
    typedef enum logic {FDB_MODE_STD, FDB_MODE_RED} fdb_mode_t;
    typedef enum logic [2:0] {
        FDB_SEC_IDLE, FDB_SEC_DEF, FDB_SEC_ID, FDB_SEC_MOD,
        FDB_SEC_MSG, FDB_SEC_HST, FDB_SEC_IRQ
    } fdb_sec_t;

    typedef struct packed {
        logic       cfg;
        logic       has_mstat;
        logic [1:0] mstat;
        logic       has_id;
        logic       id_bad;
        logic       xchg;
        logic       cfg_err;
        logic       missing;
        logic       other_err;
    } fdb_slot_t;

    typedef struct packed {
        logic       prm_req;
        logic       wd_en;
        logic       disabled;
        logic [7:0] master_addr;
    } fdb_stat_t;

    typedef struct packed {
        fdb_mode_t  mode;
        logic       sel_id;
        logic       sel_mod;
        logic       sel_msg;
        logic       irq_on;
        logic       irq_ext;
        logic [6:0] info_len;
    } fdb_cfg_t;

    typedef struct packed {
        logic [7:0] data;
        logic       last;
    } fdb_byte_t;

endpackage : fdb_pkg

// File: rtl/fdb_fifo.sv
`timescale 1ns/10ps
module fdb_fifo #(
    parameter int W     = 9,
    parameter int DEPTH = 16
)(
    // clock and reset
    input  wire logic         core_clk,
    input  wire logic         sys_rst,
    // fill side
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    // drain side
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    localparam int PW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);

    logic [W-1:0]  mem_reg [DEPTH];
    logic [PW-1:0] wr_ptr_reg;
    logic [PW-1:0] rd_ptr_reg;
    logic [CW-1:0] cnt_reg;
    logic          out_valid_reg;
    logic [W-1:0]  out_data_reg;

    wire logic push = in_valid && in_ready;
    wire logic pop  = (cnt_reg != '0) && (!out_valid_reg || out_ready);

    assign in_ready  = (cnt_reg != CW'(DEPTH));
    assign out_valid = out_valid_reg;
    assign out_data  = out_data_reg;

    always_ff @(posedge core_clk) begin
        if (push) begin
            mem_reg[wr_ptr_reg] <= in_data;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            wr_ptr_reg    <= '0;
            rd_ptr_reg    <= '0;
            cnt_reg       <= '0;
            out_valid_reg <= 1'b0;
            out_data_reg  <= '0;
        end else begin
            wr_ptr_reg <= push ? PW'((wr_ptr_reg + 1'b1) % DEPTH) : wr_ptr_reg;
            rd_ptr_reg <= pop ? PW'((rd_ptr_reg + 1'b1) % DEPTH) : rd_ptr_reg;
            cnt_reg    <= cnt_reg + CW'(push) - CW'(pop);
            if (pop) begin
                out_valid_reg <= 1'b1;
                out_data_reg  <= mem_reg[rd_ptr_reg];
            end else if (out_ready) begin
                out_valid_reg <= 1'b0;
            end
        end
    end

    AST_FIFO_HOLD: assert property (@(posedge core_clk) disable iff (sys_rst)
        out_valid && !out_ready |=> out_valid && $stable(out_data))
        else $error("fifo head changed while stalled");

endmodule : fdb_fifo

// File: rtl/fdb_frame_builder.sv
`timescale 1ns/10ps
module fdb_frame_builder
    import fdb_pkg::*;
#(
    parameter int         FIFO_DEPTH = FDB_FIFO_DEPTH,
    // arbitrary identification value
    parameter logic [7:0] IDENT_HI   = 8'h0A,
    // arbitrary identification value
    parameter logic [7:0] IDENT_LO   = 8'h5C
)(
    // clock and reset
    input  wire logic       core_clk,
    input  wire logic       sys_rst,
    // frame request
    input  wire logic       frame_req,
    output logic            busy,
    output logic            irq_type_bad,
    // configuration
    input  wire fdb_mode_t  mode,
    input  wire logic       sel_id,
    input  wire logic       sel_mod,
    input  wire logic       sel_msg,
    input  wire fdb_stat_t  stat,
    input  wire logic [7:0] station1,
    input  wire fdb_bm_t    bm_state,
    // slot states
    input  wire fdb_slot_t  slot_info [FDB_SLOTS],
    // redundancy status
    input  wire logic [7:0] h_stat [8],
    // interrupt
    input  wire logic       irq_pend,
    input  wire logic       irq_ext,
    input  wire logic [7:0] irq_type,
    input  wire logic [7:0] irq_hdr [4],
    input  wire logic [7:0] irq_info [59],
    input  wire logic [6:0] irq_info_len,
    // frame stream
    output logic            frm_valid,
    input  wire logic       frm_ready,
    output fdb_byte_t       frm_byte
);

    // ------------------------------------------------------------
    // decode functions
    // ------------------------------------------------------------
    function automatic logic [1:0] slot_code(input fdb_slot_t s);
        if (!s.cfg) begin
            return FDB_MS_OK;
        end
        if (s.has_mstat) begin
            return s.mstat;
        end
        if (s.has_id) begin
            return s.id_bad ? FDB_MS_FAULT : FDB_MS_OK;
        end
        if (s.missing) begin
            return FDB_MS_NONE;
        end
        if (s.cfg_err) begin
            return FDB_MS_WRONG;
        end
        return s.other_err ? FDB_MS_FAULT : FDB_MS_OK;
    endfunction : slot_code

    function automatic logic type_ok(input logic [7:0] t);
        return (t >= FDB_IT_DIAG && t <= FDB_IT_UPDATE) ||
               (t >= FDB_IT_MAKER_LO && t <= FDB_IT_MAKER_HI);
    endfunction : type_ok

    function automatic logic [7:0] bm_byte(input fdb_bm_t b);
        case (b)
            FDB_BM_STOP:  return FDB_BMB_STOP;
            FDB_BM_CLEAR: return FDB_BMB_CLEAR;
            FDB_BM_RUN:   return FDB_BMB_RUN;
            default:      return FDB_BMB_OFF;
        endcase
    endfunction : bm_byte

    function automatic logic [6:0] sec_len(input fdb_sec_t s, input fdb_cfg_t c);
        case (s)
            FDB_SEC_DEF: return FDB_DEF_LEN;
            FDB_SEC_ID:  return FDB_ID_LEN;
            FDB_SEC_MOD: return FDB_MOD_LEN;
            FDB_SEC_MSG: return FDB_MSG_LEN;
            FDB_SEC_HST: return FDB_H_LEN;
            FDB_SEC_IRQ: return c.irq_ext ? FDB_IRQ_HDR_LEN + c.info_len : FDB_IRQ_FIX_LEN;
            default:     return FDB_DEF_LEN;
        endcase
    endfunction : sec_len

    function automatic fdb_sec_t next_sec(input fdb_sec_t s, input logic [6:0] on);
        fdb_sec_t r;
        r = FDB_SEC_IDLE;
        for (int i = 6; i > 0; i--) begin
            if (i > int'(s) && on[i]) begin
                r = fdb_sec_t'(i);
            end
        end
        return r;
    endfunction : next_sec

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    fdb_sec_t   sec_reg;
    logic [6:0] idx_reg;
    logic [7:0] pos_reg;
    fdb_cfg_t   cfg_reg;
    logic       busy_reg;
    logic       bad_reg;

    // ------------------------------------------------------------
    // per-slot decode
    // ------------------------------------------------------------
    logic [FDB_ID_SLOTS-1:0] id_bits;
    logic [2*FDB_SLOTS-1:0]  ms_bits;

    generate
        for (genvar g = 0; g < FDB_SLOTS; g++) begin : g_slot
            assign ms_bits[2*g +: 2] = slot_code(slot_info[g]);
            if (g < FDB_ID_SLOTS) begin : g_id
                assign id_bits[g] = slot_info[g].cfg &&
                    ((slot_info[g].has_id && slot_info[g].id_bad) || !slot_info[g].xchg);
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // frame layout
    // ------------------------------------------------------------
    wire logic       red      = (cfg_reg.mode == FDB_MODE_RED);
    wire logic       type_fit = type_ok(irq_type);
    wire logic [6:0] info_cut = (irq_info_len > FDB_IRQ_INFO_MAX) ? FDB_IRQ_INFO_MAX
                                                                  : irq_info_len;
    wire logic [6:0] sec_on;
    assign sec_on[FDB_SEC_DEF]  = 1'b1;
    assign sec_on[FDB_SEC_ID]   = red || cfg_reg.sel_id;
    assign sec_on[FDB_SEC_MOD]  = red || cfg_reg.sel_mod;
    assign sec_on[FDB_SEC_MSG]  = red || cfg_reg.sel_msg;
    assign sec_on[FDB_SEC_HST]  = red;
    assign sec_on[FDB_SEC_IRQ]  = cfg_reg.irq_on;
    assign sec_on[FDB_SEC_IDLE] = 1'b0;

    wire logic       active  = (sec_reg != FDB_SEC_IDLE);
    wire logic [6:0] cur_len = sec_len(sec_reg, cfg_reg);
    wire logic       sec_end = (idx_reg == cur_len - 7'h01);
    wire fdb_sec_t   nxt     = next_sec(sec_reg, sec_on);
    wire logic       in_rdy;
    wire logic       push    = active && in_rdy;

    // ------------------------------------------------------------
    // byte generation
    // ------------------------------------------------------------
    wire logic [7:0] st2_byte;
    assign st2_byte[FDB_ST2_PRM]     = stat.prm_req;
    assign st2_byte[1]               = 1'b0;
    assign st2_byte[6:4]             = 3'h0;
    assign st2_byte[FDB_ST2_PRESENT] = 1'b1;
    assign st2_byte[FDB_ST2_WD]      = stat.wd_en;
    assign st2_byte[FDB_ST2_DIS]     = stat.disabled;

    wire logic [7:0] def_byte =
        (idx_reg == FDB_IX_ST1)   ? station1 :
        (idx_reg == FDB_IX_ST2)   ? st2_byte :
        (idx_reg == FDB_IX_ST3)   ? 8'h00 :
        (idx_reg == FDB_IX_MADDR) ? stat.master_addr :
        (idx_reg == FDB_IX_IDHI)  ? IDENT_HI : IDENT_LO;

    wire logic [7:0] id_byte  = id_bits[8*int'(idx_reg) +: 8];
    wire logic [7:0] mod_byte = ms_bits[8*int'(idx_reg) +: 8];
    wire logic [7:0] msg_byte = (idx_reg == FDB_IX_MSTATE) ? bm_byte(bm_state) : 8'h00;
    wire logic [7:0] hst_byte = h_stat[idx_reg[2:0]];
    wire logic [6:0] info_ix  = idx_reg - FDB_IRQ_HDR_LEN;

    wire logic [7:0] irq_byte =
        (idx_reg == FDB_IX_ITYPE)    ? irq_type :
        (idx_reg < FDB_IRQ_HDR_LEN)  ? irq_hdr[idx_reg[1:0]] : irq_info[info_ix[5:0]];

    wire logic [7:0] gen_data =
        (sec_reg == FDB_SEC_DEF) ? def_byte :
        (sec_reg == FDB_SEC_ID)  ? id_byte  :
        (sec_reg == FDB_SEC_MOD) ? mod_byte :
        (sec_reg == FDB_SEC_MSG) ? msg_byte :
        (sec_reg == FDB_SEC_HST) ? hst_byte : irq_byte;

    fdb_byte_t gen_byte;
    assign gen_byte.data = gen_data;
    assign gen_byte.last = sec_end && (nxt == FDB_SEC_IDLE);

    wire logic start = frame_req && !active;

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    wire fdb_sec_t   sec_next = start ? FDB_SEC_DEF :
                                (push && sec_end) ? nxt : sec_reg;
    wire logic [6:0] idx_next = start ? 7'h00 :
                                !push ? idx_reg :
                                sec_end ? 7'h00 : idx_reg + 7'h01;
    wire logic [7:0] pos_next = start ? 8'h00 : push ? pos_reg + 8'h01 : pos_reg;

    fdb_cfg_t cfg_next;
    assign cfg_next.mode     = mode;
    assign cfg_next.sel_id   = sel_id;
    assign cfg_next.sel_mod  = sel_mod;
    assign cfg_next.sel_msg  = sel_msg;
    assign cfg_next.irq_on   = irq_pend && type_fit;
    assign cfg_next.irq_ext  = irq_ext;
    assign cfg_next.info_len = info_cut;

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            sec_reg  <= FDB_SEC_IDLE;
            idx_reg  <= 7'h00;
            pos_reg  <= 8'h00;
            cfg_reg  <= '0;
            busy_reg <= 1'b0;
            bad_reg  <= 1'b0;
        end else begin
            sec_reg  <= sec_next;
            idx_reg  <= idx_next;
            pos_reg  <= pos_next;
            cfg_reg  <= start ? cfg_next : cfg_reg;
            busy_reg <= (sec_next != FDB_SEC_IDLE);
            bad_reg  <= start ? (irq_pend && !type_fit) : bad_reg;
        end
    end

    assign busy         = busy_reg;
    assign irq_type_bad = bad_reg;

    // ------------------------------------------------------------
    // output buffer
    // ------------------------------------------------------------
    fdb_fifo #(
        .W     ($bits(fdb_byte_t)),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .core_clk  (core_clk),
        .sys_rst   (sys_rst),
        .in_valid  (active),
        .in_ready  (in_rdy),
        .in_data   (gen_byte),
        .out_valid (frm_valid),
        .out_ready (frm_ready),
        .out_data  (frm_byte)
    );

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    AST_ST2_PRM: assert property (@(posedge core_clk) disable iff (sys_rst)
        push && sec_reg == FDB_SEC_DEF && idx_reg == FDB_IX_ST2
        |-> gen_data[FDB_ST2_PRM] == stat.prm_req)
        else $error("parameterization bit wrong");

    AST_ST_ZERO: assert property (@(posedge core_clk) disable iff (sys_rst)
        push && sec_reg == FDB_SEC_DEF |=> $past(idx_reg) != FDB_IX_ST3 ||
        $past(gen_data) == 8'h00)
        else $error("status 3 not zero");

    AST_ST2_BITS: assert property (@(posedge core_clk) disable iff (sys_rst)
        push && sec_reg == FDB_SEC_DEF && idx_reg == FDB_IX_ST2
        |-> gen_data[FDB_ST2_PRESENT] && (gen_data & FDB_ST2_ZMASK) == 8'h00)
        else $error("status 2 fixed bits wrong");

    AST_ST2_WD: assert property (@(posedge core_clk) disable iff (sys_rst)
        push && sec_reg == FDB_SEC_DEF && idx_reg == FDB_IX_ST2
        |-> gen_data[FDB_ST2_WD] == stat.wd_en && gen_data[FDB_ST2_DIS] == stat.disabled)
        else $error("monitor or disabled bit wrong");

    AST_MADDR: assert property (@(posedge core_clk) disable iff (sys_rst)
        push && sec_reg == FDB_SEC_DEF && pos_reg == 8'h03 |-> gen_data == stat.master_addr)
        else $error("master address misplaced");

    AST_START: assert property (@(posedge core_clk) disable iff (sys_rst)
        start |=> sec_reg == FDB_SEC_DEF && pos_reg == 8'h00 && busy ##5
        pos_reg <= 8'h05 || sec_reg == FDB_SEC_DEF)
        else $error("frame does not open with default block");

    AST_MOD_OFS: assert property (@(posedge core_clk) disable iff (sys_rst)
        push && red && sec_reg == FDB_SEC_MOD && idx_reg == 7'h00
        |-> pos_reg == FDB_OFS_MOD_FIX)
        else $error("module status offset wrong");

    AST_MSG_OFS: assert property (@(posedge core_clk) disable iff (sys_rst)
        push && red && sec_reg == FDB_SEC_MSG && idx_reg == 7'h00
        |-> pos_reg == FDB_OFS_MSG_FIX)
        else $error("status message offset wrong");

    AST_IRQ_OFS: assert property (@(posedge core_clk) disable iff (sys_rst)
        push && sec_reg == FDB_SEC_IRQ && idx_reg == 7'h00 && (red ||
        (cfg_reg.sel_id && cfg_reg.sel_mod && cfg_reg.sel_msg))
        |-> pos_reg == (red ? FDB_OFS_IRQ_RED : FDB_OFS_IRQ_STD))
        else $error("interrupt section offset wrong");

    AST_IRQ_LEN: assert property (@(posedge core_clk) disable iff (sys_rst)
        push && sec_reg == FDB_SEC_IRQ && sec_end
        |-> cfg_reg.irq_ext ? idx_reg < FDB_IRQ_MAX : idx_reg == FDB_IRQ_FIX_LEN - 7'h01)
        else $error("interrupt section length wrong");

    AST_IRQ_ONLY: assert property (@(posedge core_clk) disable iff (sys_rst)
        active && sec_reg == FDB_SEC_IRQ |-> cfg_reg.irq_on && !bad_reg)
        else $error("interrupt section without pending interrupt");

    AST_HST_RED: assert property (@(posedge core_clk) disable iff (sys_rst)
        active && sec_reg == FDB_SEC_HST |-> red)
        else $error("H status outside redundant mode");

    AST_BM_STATE: assert property (@(posedge core_clk) disable iff (sys_rst)
        push && sec_reg == FDB_SEC_MSG && idx_reg == FDB_IX_MSTATE && bm_state == FDB_BM_RUN
        |-> gen_data == FDB_BMB_RUN)
        else $error("master state byte wrong");

endmodule : fdb_frame_builder

// File: verif/fdb_master_sink.sv
`timescale 1ns/10ps
module fdb_master_sink (
    // clock and reset
    input  wire logic core_clk,
    input  wire logic sys_rst,
    // stream acceptance
    output logic      frm_ready
);
    logic [7:0] tick = 8'h00;
    // random stalls plus a long stall window to fill the buffer
    always @(negedge core_clk) begin
        tick <= tick + 8'h01;
        frm_ready <= !sys_rst && tick[7:6] != 2'h1 && $urandom_range(0, 3) != 0;
    end
endmodule : fdb_master_sink

// File: verif/test_fieldbus_diag_frame_builder.sv
`timescale 1ns/10ps
module test_fieldbus_diag_frame_builder;
    import fdb_pkg::*;
    logic       core_clk = 1'b0, sys_rst = 1'b1, frame_req = 1'b0;
    logic       busy, irq_type_bad, frm_valid, frm_ready;
    fdb_mode_t  mode = FDB_MODE_STD;
    logic       sel_id = 1'b0, sel_mod = 1'b0, sel_msg = 1'b0;
    fdb_stat_t  stat = '0;
    logic [7:0] station1 = 8'h00;
    fdb_bm_t    bm_state = FDB_BM_OFF;
    fdb_slot_t  slot_info [FDB_SLOTS];
    logic [7:0] h_stat [8], irq_hdr [4], irq_info [59];
    logic       irq_pend = 1'b0, irq_ext = 1'b0;
    logic [7:0] irq_type = 8'h00;
    logic [6:0] irq_info_len = 7'h00;
    fdb_byte_t  frm_byte;
    int         num_errors = 0, tests_run = 0;
    logic [8:0] exp_q [$];
    // arbitrary identification values, handed to the design as parameters
    localparam logic [7:0] ident_hi = 8'h0A, ident_lo = 8'h5C;
    logic [7:0] types [13] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h20,
                               8'h7E, 8'h00, 8'h07, 8'h1F, 8'h7F, 8'h01};
    always #50 core_clk = ~core_clk;
    fdb_frame_builder #(
        .FIFO_DEPTH (FDB_FIFO_DEPTH),
        .IDENT_HI   (ident_hi),
        .IDENT_LO   (ident_lo)
    ) u_fdb_frame_builder (
        .core_clk (core_clk), .sys_rst (sys_rst), .frame_req (frame_req), .busy (busy),
        .irq_type_bad (irq_type_bad), .mode (mode), .sel_id (sel_id), .sel_mod (sel_mod),
        .sel_msg (sel_msg), .stat (stat), .station1 (station1), .bm_state (bm_state),
        .slot_info (slot_info), .h_stat (h_stat), .irq_pend (irq_pend), .irq_ext (irq_ext),
        .irq_type (irq_type), .irq_hdr (irq_hdr), .irq_info (irq_info),
        .irq_info_len (irq_info_len), .frm_valid (frm_valid), .frm_ready (frm_ready),
        .frm_byte (frm_byte)
    );
    fdb_master_sink u_fdb_master_sink (.core_clk(core_clk), .sys_rst(sys_rst),
                                       .frm_ready(frm_ready));
    task automatic check(input logic [8:0] seen, input logic [8:0] want);
        tests_run++;
        if (seen !== want) begin
            num_errors++;
            $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask : check
    task automatic complete_run();
        $display("errors=%0d checks=%0d", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : complete_run
    function automatic logic [1:0] code(input fdb_slot_t s);
        if (!s.cfg) return 2'h0;
        if (s.has_mstat) return s.mstat;
        if (s.has_id) return {1'b0, s.id_bad};
        if (s.missing) return 2'h3;
        if (s.cfg_err) return 2'h2;
        return {1'b0, s.other_err};
    endfunction : code
    function automatic logic irq_ok();
        return irq_pend && ((irq_type >= 8'h01 && irq_type <= 8'h06) ||
                            (irq_type >= 8'h20 && irq_type <= 8'h7E));
    endfunction : irq_ok
    task automatic put(input logic [7:0] b);
        exp_q.push_back({b, 1'b0});
    endtask : put
    task automatic build();
        logic [7:0] b;
        logic       red;
        fdb_slot_t  s;
        int         len;
        red = (mode == FDB_MODE_RED);
        put(station1);
        put({stat.disabled, 3'h0, stat.wd_en, 1'b1, 1'b0, stat.prm_req});
        put(8'h00);
        put(stat.master_addr);
        put(ident_hi);
        put(ident_lo);
        if (red || sel_id) for (int n = 0; n < 31; n++) begin
            for (int j = 0; j < 8; j++) begin
                s = slot_info[n * 8 + j];
                b[j] = s.cfg & ((s.has_id & s.id_bad) | ~s.xchg);
            end
            put(b);
        end
        if (red || sel_mod) for (int n = 0; n < 63; n++) begin
            for (int j = 0; j < 4; j++) b[2 * j +: 2] = code(slot_info[n * 4 + j]);
            put(b);
        end
        if (red || sel_msg) for (int n = 0; n < 60; n++) put(n == 36 ? {bm_state, 6'h00} : 8'h00);
        if (red) for (int n = 0; n < 8; n++) put(h_stat[n]);
        if (irq_ok()) begin
            put(irq_hdr[0]);
            put(irq_type);
            put(irq_hdr[2]);
            put(irq_hdr[3]);
            len = irq_ext ? ((irq_info_len > 59) ? 59 : int'(irq_info_len)) : 16;
            for (int n = 0; n < len; n++) put(irq_info[n]);
        end
        exp_q[$][0] = 1'b1;
    endtask : build
    // frame content, order, packing and end marker
    always @(posedge core_clk) begin
        if (frm_valid === 1'b1 && frm_ready === 1'b1) begin
            if (exp_q.size() == 0) check(frm_byte, ~frm_byte);
            else check(frm_byte, exp_q.pop_front());
        end
    end
    initial begin
        void'($urandom(79680));
        foreach (slot_info[i]) slot_info[i] = '0;
        foreach (irq_info[i]) irq_info[i] = 8'h00;
        foreach (h_stat[i]) h_stat[i] = 8'h00;
        foreach (irq_hdr[i]) irq_hdr[i] = 8'h00;
        repeat (2) @(posedge core_clk);
        @(negedge core_clk) sys_rst = 1'b0;
        for (int k = 0; k < 13; k++) begin
            mode = fdb_mode_t'(k % 3 == 2);
            {sel_id, sel_mod, sel_msg} = 3'($urandom);
            stat = fdb_stat_t'(11'($urandom));
            station1 = 8'($urandom);
            bm_state = fdb_bm_t'(k % 4);
            foreach (slot_info[i]) slot_info[i] = fdb_slot_t'(10'($urandom));
            foreach (irq_info[i]) irq_info[i] = 8'($urandom);
            foreach (h_stat[i]) h_stat[i] = 8'($urandom);
            foreach (irq_hdr[i]) irq_hdr[i] = 8'($urandom);
            irq_pend = (k != 12);
            irq_ext = k[0];
            irq_type = types[k];
            irq_info_len = 7'($urandom_range(0, 63));
            build();
            frame_req = 1'b1;
            // request held one more edge: refused while busy
            @(negedge core_clk) check(busy, 1'b1);
            @(negedge core_clk) frame_req = 1'b0;
            for (int t = 0; t < 4000 && (exp_q.size() > 0 || busy !== 1'b0); t++) @(negedge core_clk);
            if (exp_q.size() > 0 || busy !== 1'b0) begin
                num_errors++;
                break;
            end
            // reserved type flag
            check(irq_type_bad, irq_pend && !irq_ok());
        end
        complete_run();
    end
endmodule : test_fieldbus_diag_frame_builder
